// ---- harmonic_overcurrent_stage.sv ----
// four harmonic overcurrent stages behind an apb register slave
// assumes measurements and blocking come from logic on the same clock
`timescale 1ns/1ps

module harmonic_overcurrent_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic strobe,
  input wire logic force_en,
  input wire logic blk_in,
  input wire harmonic_overcurrent_pkg::meas_t meas,
  input wire harmonic_overcurrent_pkg::stage_cfg_t cfg,
  input wire logic [31:0] stamp,
  output logic [2:0] outs,
  output harmonic_overcurrent_pkg::stage_stat_t stat,
  output harmonic_overcurrent_pkg::event_t ev
);
  import harmonic_overcurrent_pkg::*;

  logic [2:0][MAG_W-1:0] harm;
  logic [2:0][MAG_W-1:0] fund;
  logic [2:0][MAG_W-1:0] cap_cur;
  logic [2:0] cap_fault;
  logic [2:0] used;
  logic [2:0] over;
  logic [2:0] under;
  logic [2:0][WIDE_W-1:0] num;
  logic [2:0][WIDE_W-1:0] den;
  logic pickup;
  logic blk_q;
  logic eval;
  logic running;
  stage_state_t state;
  stage_state_t next_state;
  logic [2:0] next_outs;
  condition_t cond;
  logic [TIME_W-1:0] elapsed;
  logic [TIME_W-1:0] rel_cnt;
  logic [TIME_W-1:0] expected;
  logic signed [TIME_W:0] remaining;
  logic [2:0][RATIO_W-1:0] ratio;
  logic div_busy;
  logic [1:0] div_k;
  logic [5:0] div_step;
  logic [WIDE_W-1:0] div_den;
  logic [WIDE_W-1:0] div_q;
  logic [WIDE_W:0] div_r;
  logic [WIDE_W:0] div_t;

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      used[k] = (cfg.source == SRC_PHASES) || (k == 0);
      if (cfg.mode_rel) begin
        num[k] = WIDE_W'(harm[k]) * REL_SCALE;
        den[k] = WIDE_W'(fund[k]) * WIDE_W'(cfg.pickup_rel);
      end else begin
        num[k] = WIDE_W'(harm[k]) * RATIO_UNIT;
        den[k] = WIDE_W'(cfg.pickup_pu);
      end
      over[k] = used[k] && (num[k] > den[k] * RATIO_UNIT);
      under[k] = !used[k] || (num[k] < den[k] * HYST_PCT);
    end
  end

  // pick the chosen order off the stream
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      harm <= '0;
      fund <= '0;
    end else if (meas.valid) begin
      for (int k = 0; k < 3; k++) begin
        if (meas.chan == slot_chan(cfg.source, 2'(k))) begin
          if (meas.order == ORDER_FUND) begin
            fund[k] <= meas.mag;
          end
          if (meas.order == harm_order(cfg.harm_idx)) begin
            harm[k] <= meas.mag;
          end
        end
      end
    end
  end

  // blocking and pick-up latched first, state one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eval <= 1'b0;
      blk_q <= 1'b0;
      pickup <= 1'b0;
      cap_cur <= '0;
      cap_fault <= '0;
    end else begin
      eval <= strobe;
      if (strobe) begin
        blk_q <= blk_in | (force_en & cfg.soft_block);
        if (!cfg.enable) begin
          pickup <= 1'b0;
        end else if (|over) begin
          pickup <= 1'b1;
        end else if (&under) begin
          pickup <= 1'b0;
        end
        if (!pickup && (|over)) begin
          cap_cur <= harm;
          cap_fault <= over;
        end
      end
    end
  end

  assign running = pickup && !blk_q;

  always_comb begin
    next_state = state;
    if (eval) begin
      if (!cfg.enable) begin
        next_state = ST_NORMAL;
      end else if (force_en) begin
        case (cfg.force_status)
          COND_START: next_state = ST_START;
          COND_TRIP: next_state = ST_TRIP;
          COND_BLOCKED: next_state = ST_BLOCKED;
          default: next_state = ST_NORMAL;
        endcase
      end else if (running) begin
        if ({1'b0, elapsed} + 20'h1 >= {1'b0, cfg.op_delay}) begin
          next_state = ST_TRIP;
        end else begin
          next_state = ST_START;
        end
      end else if (pickup) begin
        next_state = ST_BLOCKED;
      end else begin
        next_state = ST_NORMAL;
      end
    end
    next_outs[OUT_START] = (next_state == ST_START) || (next_state == ST_TRIP);
    next_outs[OUT_TRIP] = (next_state == ST_TRIP);
    next_outs[OUT_BLOCKED] = (next_state == ST_BLOCKED);
  end

  // state moves only on the evaluation pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_NORMAL;
      outs <= '0;
      cond <= COND_NORMAL;
    end else begin
      state <= next_state;
      outs <= next_outs;
      case (next_state)
        ST_START: cond <= COND_START;
        ST_TRIP: cond <= COND_TRIP;
        ST_BLOCKED: cond <= COND_BLOCKED;
        default: cond <= COND_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      elapsed <= '0;
      rel_cnt <= '0;
      expected <= '0;
      remaining <= '0;
    end else if (eval) begin
      expected <= cfg.op_delay;
      remaining <= $signed({1'b0, cfg.op_delay}) - $signed({1'b0, elapsed});
      if (!cfg.enable || force_en) begin
        elapsed <= '0;
        rel_cnt <= '0;
      end else if (running) begin
        rel_cnt <= '0;
        if (elapsed < cfg.op_delay) begin
          elapsed <= elapsed + 19'h1;
        end
      end else if (rel_cnt >= cfg.rel_delay) begin
        elapsed <= '0;
      end else begin
        rel_cnt <= rel_cnt + 19'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev <= '0;
    end else begin
      ev.valid <= eval && (next_outs != outs);
      ev.on <= next_outs & ~outs;
      ev.off <= ~next_outs & outs;
      ev.stamp <= stamp;
      ev.fault <= cap_fault;
      ev.cur <= cap_cur;
    end
  end

  // one shared divider walks the three phases in turn, 49 clocks per phase, starting on an evaluation pulse while idle
  assign div_t = {div_r[WIDE_W-1:0], div_q[WIDE_W-1]};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_busy <= 1'b0;
      div_k <= '0;
      div_step <= '0;
      div_den <= '0;
      div_q <= '0;
      div_r <= '0;
      ratio <= '0;
    end else if (!div_busy) begin
      if (eval) begin
        div_busy <= 1'b1;
        div_k <= '0;
        div_step <= '0;
        div_den <= den[0];
        div_q <= num[0];
        div_r <= '0;
      end
    end else if (div_step != 6'(WIDE_W)) begin
      div_step <= div_step + 6'h1;
      if (div_t >= {1'b0, div_den}) begin
        div_r <= div_t - {1'b0, div_den};
        div_q <= {div_q[WIDE_W-2:0], 1'b1};
      end else begin
        div_r <= div_t;
        div_q <= {div_q[WIDE_W-2:0], 1'b0};
      end
    end else begin
      // zero setting saturates: quotient comes out all ones
      if (!used[div_k]) begin
        ratio[div_k] <= '0;
      end else if (div_q > WIDE_W'(RATIO_MAX)) begin
        ratio[div_k] <= RATIO_MAX;
      end else begin
        ratio[div_k] <= div_q[RATIO_W-1:0];
      end
      div_step <= '0;
      div_r <= '0;
      if (div_k == 2'h2) begin
        div_busy <= 1'b0;
      end else begin
        div_k <= div_k + 2'h1;
        div_den <= den[div_k + 2'h1];
        div_q <= num[div_k + 2'h1];
      end
    end
  end

  assign stat = '{cond: cond, ratio: ratio, expected: expected, remaining: remaining};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_normal_eval;
    eval && cfg.enable && !force_en;
  endsequence
  sequence s_blocked_pickup;
    s_normal_eval ##0 pickup && blk_q;
  endsequence

  chk_start_unblocked: assert property (
      s_normal_eval ##0 !blk_q && pickup |=> outs[OUT_START])
    else $error("start missing with unblocked pick-up");
  chk_no_bare_start: assert property (s_normal_eval ##0 blk_q |=> !outs[OUT_START])
    else $error("start raised while blocked");
  chk_blocked_state: assert property (
      s_blocked_pickup |=> state == ST_BLOCKED && !outs[OUT_TRIP])
    else $error("blocked pick-up did not block");
  chk_block_drops: assert property (
      s_blocked_pickup ##0 outs[OUT_START] |=> !outs[OUT_START])
    else $error("start held after blocking");
  chk_pickup_set: assert property (strobe && cfg.enable && (|over) |=> pickup)
    else $error("pick-up missed an over phase");
  chk_pickup_hold: assert property (strobe && cfg.enable && pickup && !(&under) |=> pickup)
    else $error("pick-up released above 97 percent");
  chk_force_state: assert property (
      eval && cfg.enable && force_en |=> cond == $past(cfg.force_status))
    else $error("forced status not shown");
  // event word is registered on the same edge as the outputs
  chk_block_event: assert property (
      $rose(outs[OUT_BLOCKED]) |-> ev.valid && ev.on[OUT_BLOCKED] && ev.cur == $past(cap_cur))
    else $error("blocking event missing");
  chk_ratio_range: assert property (
      ratio[0] <= RATIO_MAX && ratio[1] <= RATIO_MAX && ratio[2] <= RATIO_MAX)
    else $error("ratio above range");
  chk_state_on_eval: assert property (state != $past(state) |-> $past(eval))
    else $error("state moved off the cycle pulse");
  chk_trip_time: assert property (
      s_normal_eval ##0 running ##1 $rose(outs[OUT_TRIP]) |->
      elapsed >= $past(elapsed) && $past(elapsed) + 19'h1 >= cfg.op_delay)
    else $error("trip before delay ran out");
endmodule

module harmonic_overcurrent_stage #(
  parameter int CYCLE_CLOCKS = harmonic_overcurrent_pkg::CYCLE_CLKS,
  parameter int STAMP_CLOCKS = harmonic_overcurrent_pkg::STAMP_CLKS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire harmonic_overcurrent_pkg::meas_t meas,
  input wire logic [harmonic_overcurrent_pkg::NUM_STAGES-1:0] block_in,
  output logic [harmonic_overcurrent_pkg::NUM_STAGES-1:0] start,
  output logic [harmonic_overcurrent_pkg::NUM_STAGES-1:0] trip,
  output logic [harmonic_overcurrent_pkg::NUM_STAGES-1:0] blocked,
  output harmonic_overcurrent_pkg::event_t [harmonic_overcurrent_pkg::NUM_STAGES-1:0] events
);
  import harmonic_overcurrent_pkg::*;

  localparam int CYC_W = $clog2(CYCLE_CLOCKS);
  localparam int STP_W = $clog2(STAMP_CLOCKS);

  logic [CYC_W-1:0] cyc_cnt;
  logic [STP_W-1:0] stp_cnt;
  logic strobe;
  logic [31:0] stamp;
  logic force_en;
  stage_cfg_t cfg [NUM_STAGES];
  stage_stat_t stat [NUM_STAGES];
  logic [1:0] sel;
  logic [5:0] off;
  logic stage_hit;
  logic mapped;
  logic [31:0] rdata;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_cnt <= '0;
      strobe <= 1'b0;
    end else begin
      strobe <= (cyc_cnt == CYC_W'(CYCLE_CLOCKS - 1));
      cyc_cnt <= (cyc_cnt == CYC_W'(CYCLE_CLOCKS - 1)) ? '0 : cyc_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stp_cnt <= '0;
      stamp <= '0;
    end else if (stp_cnt == STP_W'(STAMP_CLOCKS - 1)) begin
      stp_cnt <= '0;
      stamp <= stamp + 32'h1;
    end else begin
      stp_cnt <= stp_cnt + 1'b1;
    end
  end

  assign sel = paddr[7:6];
  assign off = paddr[5:0];
  assign stage_hit = (paddr[11:8] == STAGE_PAGE) && (paddr[1:0] == 2'h0);

  // per-stage settings, pick-up clamped to range
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_en <= 1'b0;
      for (int s = 0; s < NUM_STAGES; s++) begin
        cfg[s] <= CFG_RESET;
      end
    end else if (psel && penable && pwrite) begin
      if (paddr == REG_GLOBAL) begin
        force_en <= pwdata[GLB_FORCE];
      end else if (stage_hit && off == STG_CTRL) begin
        cfg[sel].enable <= pwdata[CTRL_ENABLE];
        cfg[sel].mode_rel <= pwdata[CTRL_MODE];
        cfg[sel].source <= (pwdata[CTRL_SRC +: 2] == 2'h3) ? SRC_PHASES
                                                            : source_t'(pwdata[CTRL_SRC +: 2]);
        cfg[sel].harm_idx <= (pwdata[CTRL_HARM +: 4] > HARM_LAST) ? HARM_LAST
                                                                    : pwdata[CTRL_HARM +: 4];
        cfg[sel].soft_block <= pwdata[CTRL_SOFT_BLOCK];
        cfg[sel].force_status <= condition_t'(pwdata[CTRL_FORCE +: 2]);
      end else if (stage_hit && off == STG_PICKUP_PU) begin
        if (pwdata > 32'(PU_MAX)) begin
          cfg[sel].pickup_pu <= PU_MAX;
        end else if (pwdata < 32'(PU_MIN)) begin
          cfg[sel].pickup_pu <= PU_MIN;
        end else begin
          cfg[sel].pickup_pu <= pwdata[PU_W-1:0];
        end
      end else if (stage_hit && off == STG_PICKUP_REL) begin
        if (pwdata > 32'(REL_MAX)) begin
          cfg[sel].pickup_rel <= REL_MAX;
        end else if (pwdata < 32'(REL_MIN)) begin
          cfg[sel].pickup_rel <= REL_MIN;
        end else begin
          cfg[sel].pickup_rel <= pwdata[REL_W-1:0];
        end
      end else if (stage_hit && off == STG_OP_DELAY) begin
        cfg[sel].op_delay <= (pwdata > 32'(TIME_MAX)) ? TIME_MAX : pwdata[TIME_W-1:0];
      end else if (stage_hit && off == STG_REL_DELAY) begin
        cfg[sel].rel_delay <= (pwdata > 32'(TIME_MAX)) ? TIME_MAX : pwdata[TIME_W-1:0];
      end
    end
  end

  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    if (paddr == REG_GLOBAL) begin
      rdata[GLB_FORCE] = force_en;
    end else if (paddr == REG_STAMP) begin
      rdata = stamp;
    end else if (stage_hit && off == STG_CTRL) begin
      rdata[CTRL_ENABLE] = cfg[sel].enable;
      rdata[CTRL_MODE] = cfg[sel].mode_rel;
      rdata[CTRL_SRC +: 2] = cfg[sel].source;
      rdata[CTRL_HARM +: 4] = cfg[sel].harm_idx;
      rdata[CTRL_SOFT_BLOCK] = cfg[sel].soft_block;
      rdata[CTRL_FORCE +: 2] = cfg[sel].force_status;
    end else if (stage_hit && off == STG_PICKUP_PU) begin
      rdata = 32'(cfg[sel].pickup_pu);
    end else if (stage_hit && off == STG_PICKUP_REL) begin
      rdata = 32'(cfg[sel].pickup_rel);
    end else if (stage_hit && off == STG_OP_DELAY) begin
      rdata = 32'(cfg[sel].op_delay);
    end else if (stage_hit && off == STG_REL_DELAY) begin
      rdata = 32'(cfg[sel].rel_delay);
    end else if (stage_hit && off == STG_COND) begin
      rdata = 32'(stat[sel].cond);
    end else if (stage_hit && off == STG_RATIO_L1) begin
      rdata = 32'(stat[sel].ratio[0]);
    end else if (stage_hit && off == STG_RATIO_L2) begin
      rdata = 32'(stat[sel].ratio[1]);
    end else if (stage_hit && off == STG_RATIO_L3) begin
      rdata = 32'(stat[sel].ratio[2]);
    end else if (stage_hit && off == STG_EXPECT) begin
      rdata = 32'(stat[sel].expected);
    end else if (stage_hit && off == STG_REMAIN) begin
      rdata = 32'(signed'(stat[sel].remaining));
    end else begin
      mapped = 1'b0;
    end
  end

  // read data and error captured in the setup phase, so access takes one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rdata;
      pslverr <= !mapped;
    end
  end

  assign pready = psel && penable;

  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    logic [2:0] outs;
    harmonic_overcurrent_core u_core (
      .clk(clk),
      .resetn(resetn),
      .strobe(strobe),
      .force_en(force_en),
      .blk_in(block_in[s]),
      .meas(meas),
      .cfg(cfg[s]),
      .stamp(stamp),
      .outs(outs),
      .stat(stat[s]),
      .ev(events[s])
    );
    assign start[s] = outs[OUT_START];
    assign trip[s] = outs[OUT_TRIP];
    assign blocked[s] = outs[OUT_BLOCKED];
  end
endmodule

// ---- harmonic_overcurrent_pkg.sv ----
// constants, types and register map of the four-stage harmonic overcurrent block
// assumes one 20 MHz clock and magnitudes from a same-clock pre-processing stream
//
// Summary of operation
// - forced status works only in stage-forcing mode
// - monitored harmonic chosen from list, default second
// - per-unit or relative-to-fundamental monitoring mode
// - source: three phases, residual one or two
// - each stage keeps its own settings
// - four independent stages with own events
// - ratio of measured to setting per phase
// - common setting, pick-up on any phase over
// - pick-up releases below 97 percent
// - pick-up setting ranges and defaults
// - start needs pick-up and no blocking
// - read-only state code normal/start/trip/blocked
// - read-only ratio 0.00 to 100000.00
// - read-only expected operating time, 5 ms steps
// - read-only signed time remaining to trip
// - blocking sampled at start of each cycle
// - blocked pick-up gives blocked, no timing
// - blocking during start drops start, releases
// - blocking event carries currents and fault type
// - software switch drives blocking while forcing
// - on/off events per output, 1 ms stamps
package harmonic_overcurrent_pkg;
  localparam int NUM_STAGES = 4;
  localparam int CLK_HZ = 20_000_000;
  localparam int CYCLE_US = 5000;
  localparam int CYCLE_CLKS = CYCLE_US * (CLK_HZ / 1_000_000);
  localparam int STAMP_US = 1000;
  localparam int STAMP_CLKS = STAMP_US * (CLK_HZ / 1_000_000);

  localparam int MAG_W = 16;
  localparam int RATIO_W = 24;
  localparam int TIME_W = 19;
  localparam int PU_W = 8;
  localparam int REL_W = 15;
  localparam int WIDE_W = 48;

  localparam logic [WIDE_W-1:0] RATIO_UNIT = 48'h64;
  localparam logic [WIDE_W-1:0] HYST_PCT = 48'h61;
  localparam logic [WIDE_W-1:0] REL_SCALE = 48'hf4240;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 24'h989680;
  localparam logic [PU_W-1:0] PU_MIN = 8'h05;
  localparam logic [PU_W-1:0] PU_MAX = 8'hc8;
  localparam logic [PU_W-1:0] PU_DEFAULT = 8'h14;
  localparam logic [REL_W-1:0] REL_MIN = 15'h1f4;
  localparam logic [REL_W-1:0] REL_MAX = 15'h4e20;
  localparam logic [REL_W-1:0] REL_DEFAULT = 15'h7d0;
  localparam logic [TIME_W-1:0] TIME_MAX = 19'h57e40;
  localparam logic [TIME_W-1:0] OP_DELAY_DEFAULT = 19'h14;

  localparam logic [4:0] ORDER_FUND = 5'h01;
  localparam logic [3:0] HARM_LAST = 4'hb;
  localparam logic [2:0] CHAN_RES_ONE = 3'h3;
  localparam logic [2:0] CHAN_RES_TWO = 3'h4;
  localparam logic [2:0] CHAN_NONE = 3'h7;

  localparam int OUT_START = 0;
  localparam int OUT_TRIP = 1;
  localparam int OUT_BLOCKED = 2;

  localparam logic [11:0] REG_GLOBAL = 12'h000;
  localparam logic [11:0] REG_STAMP = 12'h004;
  localparam logic [3:0] STAGE_PAGE = 4'h1;
  localparam logic [5:0] STG_CTRL = 6'h00;
  localparam logic [5:0] STG_PICKUP_PU = 6'h04;
  localparam logic [5:0] STG_PICKUP_REL = 6'h08;
  localparam logic [5:0] STG_OP_DELAY = 6'h0c;
  localparam logic [5:0] STG_REL_DELAY = 6'h10;
  localparam logic [5:0] STG_COND = 6'h14;
  localparam logic [5:0] STG_RATIO_L1 = 6'h18;
  localparam logic [5:0] STG_RATIO_L2 = 6'h1c;
  localparam logic [5:0] STG_RATIO_L3 = 6'h20;
  localparam logic [5:0] STG_EXPECT = 6'h24;
  localparam logic [5:0] STG_REMAIN = 6'h28;

  localparam int GLB_FORCE = 0;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_SRC = 2;
  localparam int CTRL_HARM = 4;
  localparam int CTRL_SOFT_BLOCK = 8;
  localparam int CTRL_FORCE = 9;

  typedef enum logic [1:0] {
    SRC_PHASES = 2'h0,
    SRC_RES_ONE = 2'h1,
    SRC_RES_TWO = 2'h2
  } source_t;

  typedef enum logic [1:0] {
    COND_NORMAL = 2'h0,
    COND_START = 2'h1,
    COND_TRIP = 2'h2,
    COND_BLOCKED = 2'h3
  } condition_t;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_START = 4'b0010,
    ST_TRIP = 4'b0100,
    ST_BLOCKED = 4'b1000
  } stage_state_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [4:0] order;
    logic [MAG_W-1:0] mag;
  } meas_t;

  typedef struct packed {
    logic enable;
    logic mode_rel;
    source_t source;
    logic [3:0] harm_idx;
    logic soft_block;
    condition_t force_status;
    logic [PU_W-1:0] pickup_pu;
    logic [REL_W-1:0] pickup_rel;
    logic [TIME_W-1:0] op_delay;
    logic [TIME_W-1:0] rel_delay;
  } stage_cfg_t;

  typedef struct packed {
    condition_t cond;
    logic [2:0][RATIO_W-1:0] ratio;
    logic [TIME_W-1:0] expected;
    logic signed [TIME_W:0] remaining;
  } stage_stat_t;

  typedef struct packed {
    logic valid;
    logic [2:0] on;
    logic [2:0] off;
    logic [2:0] fault;
    logic [31:0] stamp;
    logic [2:0][MAG_W-1:0] cur;
  } event_t;

  localparam stage_cfg_t CFG_RESET = '{enable: 1'b0, mode_rel: 1'b0, source: SRC_PHASES,
    harm_idx: 4'h0, soft_block: 1'b0, force_status: COND_NORMAL, pickup_pu: PU_DEFAULT,
    pickup_rel: REL_DEFAULT, op_delay: OP_DELAY_DEFAULT, rel_delay: 19'h0};

  function automatic logic [4:0] harm_order(input logic [3:0] idx);
    case (idx)
      4'h0: harm_order = 5'h02;
      4'h1: harm_order = 5'h03;
      4'h2: harm_order = 5'h04;
      4'h3: harm_order = 5'h05;
      4'h4: harm_order = 5'h06;
      4'h5: harm_order = 5'h07;
      4'h6: harm_order = 5'h09;
      4'h7: harm_order = 5'h0b;
      4'h8: harm_order = 5'h0d;
      4'h9: harm_order = 5'h0f;
      4'ha: harm_order = 5'h11;
      default: harm_order = 5'h13;
    endcase
  endfunction

  function automatic logic [2:0] slot_chan(input source_t src, input logic [1:0] slot);
    if (src == SRC_PHASES) begin
      slot_chan = {1'b0, slot};
    end else if (slot != 2'h0) begin
      slot_chan = CHAN_NONE;
    end else if (src == SRC_RES_ONE) begin
      slot_chan = CHAN_RES_ONE;
    end else begin
      slot_chan = CHAN_RES_TWO;
    end
  endfunction
endpackage

// ---- meas_source.sv ----
// far-side model: measurement stream feeding the harmonic stages
// assumes the block's clock; one word per clock, channels 0..3 in turn,
// second harmonic and fundamental words alternating per round
`timescale 1ns/1ps
module meas_source (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [harmonic_overcurrent_pkg::MAG_W-1:0] mag,
  input wire logic [harmonic_overcurrent_pkg::MAG_W-1:0] fmag,
  output harmonic_overcurrent_pkg::meas_t meas
);
  import harmonic_overcurrent_pkg::*;
  logic [1:0] slot;
  logic fund_word;
  // every channel refreshed well inside one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot <= 2'h0;
      fund_word <= 1'b0;
      meas <= '0;
    end else begin
      slot <= slot + 2'h1;
      if (slot == 2'h3) begin
        fund_word <= !fund_word;
      end
      meas <= '{valid: 1'b1, chan: {1'b0, slot}, order: fund_word ? 5'h01 : 5'h02,
        mag: fund_word ? fmag : mag};
    end
  end
endmodule

// ---- tb.sv ----
// self-checking bench for the harmonic overcurrent stages
// assumes short cycle parameters so that each evaluation takes 64 clocks
`timescale 1ns/1ps
module tb;
  import harmonic_overcurrent_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr;
  logic [MAG_W-1:0] mag = 16'h0;
  logic [3:0] block_in = 4'h0, start, trip, blocked;
  meas_t meas;
  event_t [3:0] events;
  event_t ev0;
  int error_cnt = 0, checks = 0, cyc = 0;
  meas_source i_meas_source(.clk(clk), .resetn(resetn), .mag(mag), .fmag(16'h64), .meas(meas));
  harmonic_overcurrent_stage #(.CYCLE_CLOCKS(64), .STAMP_CLOCKS(16)) i_harmonic_overcurrent_stage (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
    .block_in(block_in), .start(start), .trip(trip), .blocked(blocked), .events(events));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic final_report;
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: a following call never reassigns psel in this step
    @(posedge clk);
  endtask
  task automatic chk_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // three 64-clock evaluations plus 8 clocks
  task automatic settle;
    repeat (200) @(posedge clk);
  endtask
  task automatic t_defaults;
    chk_reg("pickup_pu", 12'h104, 32'h14);
    chk_reg("pickup_rel", 12'h108, 32'h7d0);
    chk_reg("ctrl", 12'h100, 32'h0);
    chk_reg("stage3_pu", 12'h1c4, 32'h14);
    apb(1'b1, 12'h1c0, 32'hf0);
    chk_reg("harm_clamp", 12'h1c0, 32'hb0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
  endtask
  // stage 0 phases per unit, stage 1 relative, stage 2 residual one with instant trip
  task automatic t_pickup;
    apb(1'b1, 12'h18c, 32'h1);
    apb(1'b1, 12'h180, 32'h5);
    apb(1'b1, 12'h140, 32'h3);
    apb(1'b1, 12'h100, 32'h1);
    mag <= 16'h1e;
    settle;
    chk("start", 32'h7, {28'h0, start});
    chk("trip", 32'h4, {28'h0, trip});
    chk_reg("state", 12'h114, 32'h1);
    // the shared divider may need three evaluations to refresh a phase
    settle;
    chk_reg("ratio_l2", 12'h11c, 32'h96);
    chk_reg("ratio_rel", 12'h158, 32'h96);
    chk_reg("ratio_res", 12'h198, 32'h96);
    chk_reg("expected", 12'h1a4, 32'h1);
    chk_reg("remaining", 12'h1a8, 32'h0);
    mag <= 16'h14;
    settle;
    chk("start_hold", 32'h7, {28'h0, start});
    mag <= 16'h13;
    settle;
    chk("start_drop", 32'h0, {28'h0, start});
  endtask
  task automatic t_block;
    mag <= 16'h1e;
    settle;
    // block raised long before the operating delay runs out
    block_in <= 4'h1;
    settle;
    chk("start", 32'h6, {28'h0, start});
    chk("blocked", 32'h1, {28'h0, blocked});
    chk("ev_on_off", 32'h21, {26'h0, ev0.on, ev0.off});
    chk("ev_cur", 32'h1e, {16'h0, ev0.cur[0]});
    chk("ev_fault", 32'h7, {29'h0, ev0.fault});
    chk_reg("state", 12'h114, 32'h3);
    block_in <= 4'h0;
    mag <= 16'h0;
    settle;
    chk("blocked_off", 32'h0, {28'h0, blocked});
  endtask
  task automatic t_force;
    apb(1'b1, 12'h100, 32'h401);
    settle;
    chk_reg("state", 12'h114, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    settle;
    chk_reg("state_forced", 12'h114, 32'h2);
    chk("trip", 32'h1, {28'h0, trip});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (events[0].valid) begin
      ev0 <= events[0];
    end
    if (cyc == 10000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_defaults;
    t_pickup;
    t_block;
    t_force;
    final_report;
  end
endmodule
